// ---- verilog/btb_pkg.sv ----
/*
  Package for the basic timer time base: register offsets, field layouts,
  reset values and the APB request carrier.
  Assumes a 32-bit APB with byte addresses and word-aligned registers.
*/
package btb_pkg;
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_STATUS      = 8'h10;
  localparam logic [7:0]  OFF_EVENT_GEN   = 8'h14;
  localparam logic [7:0]  OFF_IRQ_CLEAR   = 8'h18;
  localparam logic [7:0]  OFF_IRQ_ENABLE  = 8'h1c;
  localparam logic [7:0]  OFF_COUNTER     = 8'h24;
  localparam logic [7:0]  OFF_PRESCALER   = 8'h28;
  localparam logic [7:0]  OFF_AUTO_RELOAD = 8'h2c;
  localparam logic [7:0]  OFF_SLAVE_RESET = 8'h30;

  localparam int          BIT_UPDATE_GEN  = 0;
  localparam int          BIT_UPD_DISABLE = 0;
  localparam int          BIT_UPD_SOURCE  = 1;
  localparam int          BIT_UPDATE_FLAG = 0;
  localparam int          BIT_SLAVE_RESET = 0;

  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [15:0] DIVIDER_RESET   = 16'h0000;
  localparam logic [31:0] RELOAD_RESET    = 32'h0000_0000;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;

  typedef struct packed {
    logic              sel;
    logic              enable;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } btb_apb_req_t;
endpackage

// ---- verilog/btb_timer.sv ----
/*
  Basic timer time base with APB register slave and update interrupt.
  Holds the 16-bit up-counter, the prescaler counter, the buffered
  prescaler and reload registers, the self-clearing update_generate bit,
  the sticky update_pending_flag and its level interrupt.
  Register map, byte offsets, one aligned 32-bit word each:
    0x00 control: bit 0 update_disable, bit 1 update_source_select
    0x10 status, read only: bit 0 update_pending_flag
    0x14 event_generation, write only: bit 0 update_generate
    0x18 interrupt clear, write only: write one to bit 0
    0x1c interrupt enable: bit 0
    0x24 counter_value: bits 15:0
    0x28 prescaler_value: bits 15:0, preload copy
    0x2c auto_reload_value: bits 31:0, preload copy
    0x30 slave reset, write only: bit 0 stands in for the trigger
         controller clearing the counter in reset mode
  Assumes one kernel clock pclk (25 MHz) and asynchronous active-low reset;
  the APB master keeps to the standard two-phase protocol and every
  access completes with no wait state; other offsets answer pslverr.
*/
// What this block does
// (R01) update_generate bit self-clears in hardware
// (R02) writing one restarts counter and updates registers
// (R03) forced update clears prescaler counter, keeps ratio
// (R04) counter value is 16-bit read/write
// (R05) count_clock equals input clock over divider+1
// (R06) divider preload copies to active on update
// (R07) preload also copies on software or slave reset
// (R08) 32-bit reload value moves to active register
// (R09) zero reload value keeps counter stopped
// (R10) software writes zero above update_generate bit
// (R11) pending flag on overflow or forced update rules
// (R12) count up, wrap at reload, raise overflow
// (R13) reserved bits read zero, writes ignored
`timescale 1ns/10ps
module btb_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             update_event
);

  btb_pkg::btb_apb_req_t req;
  // decoded bus strobes, all but setup qualified by the access phase
  logic        wr_en;
  logic        setup;
  logic        wr_ctrl;
  logic        wr_count;
  logic        wr_div;
  logic        wr_reload;
  logic        wr_clear;
  logic        wr_ien;
  logic        upd_gen_wr;
  logic        slave_rst;
  // internal events of the time base
  logic        sw_update;
  logic        any_update;
  logic        tick;
  logic        overflow;
  logic        flag_set;
  logic        mapped;
  logic [31:0] rd_nxt;

  // timer and register state
  logic [15:0] count_value_r;
  logic [15:0] div_preload_r;
  logic [15:0] div_active_r;
  logic [15:0] div_count_r;
  logic [31:0] reload_preload_r;
  logic [31:0] reload_active_r;
  logic [1:0]  ctrl_r;
  logic        update_generate_r;
  logic        update_pending_flag_r;
  logic        irq_enable_r;

  // carrier bundles the bus request
  assign req = '{sel:    psel,
                 enable: penable,
                 write:  pwrite,
                 addr:   paddr,
                 wdata:  pwdata};

  // zero-wait slave: access phase always completes in its first cycle
  assign wr_en = req.sel && req.enable && req.write;
  assign setup = req.sel && !req.enable;

  // one strobe per writable register; unmapped writes match none [R13]
  assign wr_ctrl   = wr_en && (req.addr == btb_pkg::OFF_CTRL);
  assign wr_count  = wr_en && (req.addr == btb_pkg::OFF_COUNTER);
  assign wr_div    = wr_en && (req.addr == btb_pkg::OFF_PRESCALER);
  assign wr_reload = wr_en && (req.addr == btb_pkg::OFF_AUTO_RELOAD);
  assign wr_clear  = wr_en && (req.addr == btb_pkg::OFF_IRQ_CLEAR);
  assign wr_ien    = wr_en && (req.addr == btb_pkg::OFF_IRQ_ENABLE);

  // only bit 0 acts; upper bits are expected zero from software [R10]
  assign upd_gen_wr = wr_en && (req.addr == btb_pkg::OFF_EVENT_GEN)
                      && req.wdata[btb_pkg::BIT_UPDATE_GEN]; // [R02]
  assign slave_rst = wr_en && (req.addr == btb_pkg::OFF_SLAVE_RESET)
                     && req.wdata[btb_pkg::BIT_SLAVE_RESET];

  // forced update acts one cycle after the write via the self-clearing bit
  // so the bus write and the restart never meet in one cycle
  assign sw_update = update_generate_r; // [R02]

  // prescaler terminal count gives the one-cycle count_clock enable
  // a divider of zero ticks every cycle, so no division at all
  assign tick = (div_count_r == div_active_r); // [R05]

  // zero reload blocks both advance and overflow
  // >= so a counter written above the reload wraps at the next tick
  assign overflow = tick && (reload_active_r != 32'h0000_0000)
                    && ({16'h0000, count_value_r} >= reload_active_r);

  // overflow updates gated by update_disable, forced updates always load
  // slave reset stands in for the trigger controller's reset mode
  assign any_update = sw_update || slave_rst
                      || (overflow && !ctrl_r[btb_pkg::BIT_UPD_DISABLE]);

  // pending flag sources [R11]
  // update_source_select set keeps forced updates quiet
  assign flag_set = !ctrl_r[btb_pkg::BIT_UPD_DISABLE] &&
                    (overflow ||
                     (sw_update && !ctrl_r[btb_pkg::BIT_UPD_SOURCE]));

  // update_generate bit: set by write, cleared by hardware next cycle
  // never readable, so software needs no way to clear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      update_generate_r <= 1'b0;
    end else begin
      update_generate_r <= upd_gen_wr; // [R01]
    end
  end

  // prescaler counter, cleared on forced updates
  // runs 0..div_active_r, so a new ratio waits for an update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count_r <= btb_pkg::DIVIDER_RESET;
    end else if (sw_update || slave_rst) begin
      div_count_r <= 16'h0000; // [R03]
    end else if (tick) begin
      div_count_r <= 16'h0000; // [R05]
    end else begin
      div_count_r <= div_count_r + 16'h0001;
    end
  end

  // main counter; a forced restart beats a same-cycle software write
  // so that the restart is never undone by a stale bus value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_r <= btb_pkg::COUNT_RESET;
    end else if (sw_update || slave_rst) begin
      count_value_r <= 16'h0000; // [R02]
    end else if (wr_count) begin
      count_value_r <= req.wdata[15:0]; // [R04]
    end else if (overflow) begin
      count_value_r <= 16'h0000; // [R12]
    end else if (tick && reload_active_r != 32'h0000_0000) begin // [R09]
      count_value_r <= count_value_r + 16'h0001; // [R12]
    end
  end

  // prescaler preload, written by software, read back as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_preload_r <= btb_pkg::DIVIDER_RESET;
    end else if (wr_div) begin
      div_preload_r <= req.wdata[15:0]; // [R06] [R13]
    end
  end

  // reload preload; the counter only sees it after an update event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_preload_r <= btb_pkg::RELOAD_RESET;
    end else if (wr_reload) begin
      reload_preload_r <= req.wdata; // [R08]
    end
  end

  // control bits update_disable and update_source_select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= btb_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= req.wdata[1:0]; // [R13]
    end
  end

  // active copies load only on update events
  // trade-off: reload is buffered always, so a new period starts cleanly
  // both copies move on the same edge, never one without the other
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_active_r    <= btb_pkg::DIVIDER_RESET;
      reload_active_r <= btb_pkg::RELOAD_RESET;
    end else if (any_update) begin
      div_active_r    <= div_preload_r; // [R06] [R07]
      reload_active_r <= reload_preload_r; // [R08]
    end
  end

  // sticky pending flag: set wins over a same-cycle clear
  // a clear needs a one in bit 0; zeros leave the flag alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      update_pending_flag_r <= 1'b0;
    end else if (flag_set) begin
      update_pending_flag_r <= 1'b1; // [R11]
    end else if (wr_clear && req.wdata[btb_pkg::BIT_UPDATE_FLAG]) begin
      update_pending_flag_r <= 1'b0;
    end
  end

  // interrupt enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_r <= 1'b0;
    end else if (wr_ien) begin
      irq_enable_r <= req.wdata[btb_pkg::BIT_UPDATE_FLAG];
    end
  end

  // read mux; reserved bits and write-only registers read zero
  // prescaler reads return the preload, the value software wrote
  always_comb begin
    rd_nxt = 32'h0000_0000;
    mapped = 1'b1;
    case (req.addr)
      btb_pkg::OFF_CTRL: begin
        rd_nxt = {30'h0, ctrl_r};
      end
      btb_pkg::OFF_STATUS: begin
        rd_nxt = {31'h0, update_pending_flag_r};
      end
      btb_pkg::OFF_EVENT_GEN: begin
        rd_nxt = 32'h0000_0000; // [R13]
      end
      btb_pkg::OFF_IRQ_CLEAR: begin
        rd_nxt = 32'h0000_0000;
      end
      btb_pkg::OFF_IRQ_ENABLE: begin
        rd_nxt = {31'h0, irq_enable_r};
      end
      btb_pkg::OFF_COUNTER: begin
        rd_nxt = {16'h0, count_value_r}; // [R04]
      end
      btb_pkg::OFF_PRESCALER: begin
        rd_nxt = {16'h0, div_preload_r}; // [R13]
      end
      btb_pkg::OFF_AUTO_RELOAD: begin
        rd_nxt = reload_preload_r;
      end
      btb_pkg::OFF_SLAVE_RESET: begin
        rd_nxt = 32'h0000_0000;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // registered bus answers: pready rises in the first access cycle
  // answers come from the setup cycle, so no wait state is ever needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && !req.write) ? rd_nxt : 32'h0000_0000;
    end
  end

  // level interrupt; flag_set is included so irq rises with the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (update_pending_flag_r || flag_set) && irq_enable_r; // [R11]
    end
  end

  // one-cycle pulse per update event, high while new values first stand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      update_event <= 1'b0;
    end else begin
      update_event <= any_update; // [R02]
    end
  end

endmodule

// ---- bench/btb_timer_props.sv ----
/* checker: apb timing and readback properties of the timer.
   assumes binding to btb_timer, seeing its ports only. */
`timescale 1ns/10ps
module btb_timer_props (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        irq,
  input logic        update_event
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic mapped;
  // offsets that answer without an error
  assign mapped = paddr inside {8'h00, 8'h10, 8'h14, 8'h18, 8'h1c,
                                8'h24, 8'h28, 8'h2c, 8'h30};
  // access edge, read access, forced update write
  sequence acc_s;
    psel && penable && pready;
  endsequence
  sequence rd_s;
    acc_s ##0 !pwrite;
  endsequence
  sequence force_s;
    acc_s ##0 pwrite && paddr == 8'h14 && pwdata[0];
  endsequence
  ready_one_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_map_a: assert property (pready |-> pslverr == !mapped)
    else $error("error flag wrong for offset");
  err_rdata_a: assert property (pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  force_event_a: assert property (force_s |=> ##1 update_event)
    else $error("forced update missing");
  count_upper_a: assert property (rd_s ##0 paddr == 8'h24
    |-> prdata[31:16] == 16'h0) else $error("counter upper bits set");
  divider_upper_a: assert property (rd_s ##0 paddr == 8'h28
    |-> prdata[31:16] == 16'h0) else $error("divider upper bits set");
endmodule
bind btb_timer btb_timer_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq), .update_event(update_event));

// ---- bench/testbench.sv ----
/* testbench: random and corner apb traffic for the timer time base.
   assumes a zero-wait apb slave and the package offsets. */
`timescale 1ns/10ps
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        update_event;
  logic [31:0] seed = 32'hc2db6534;
  logic [31:0] q;
  logic [31:0] v;
  logic        e;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n;
  int          p;
  int          a;
  btb_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .update_event(update_event));
  always #20 pclk = ~pclk;
  // hang guard, the run needs well under this
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic test_done();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // idle edge first, so strobes never toggle twice in one step
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] x);
    apb(1'b0, ad, 32'h0);
    chk(q, x);
  endtask
  // cycles until the next update pulse
  task automatic gap();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (update_event !== 1'b1);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++)
      rd(8'h24 + 8'(4 * i), 32'h0);
    // v keeps the random word; apb overwrites q with read data
    v = rnd();
    apb(1'b1, 8'h24, v);
    rd(8'h24, {16'h0, v[15:0]});
    apb(1'b1, 8'h28, v);
    rd(8'h28, {16'h0, v[15:0]});
    apb(1'b1, 8'h2c, ~v);
    rd(8'h2c, ~v);
    rd(8'h24, {16'h0, v[15:0]});
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 8'h1c, 32'h1);
    // each pass: load, force, then stop with a zero reload
    for (int k = 0; k < 5; k++) begin
      p = (k == 0) ? 0 : int'(rnd() % 4);
      a = (k == 1) ? 1 : int'(rnd() % 7) + 1;
      apb(1'b1, 8'h28, 32'(p));
      apb(1'b1, 8'h2c, 32'(a));
      apb(1'b1, 8'h14, 32'h1);
      gap();
      chk(32'(n), 32'h2);
      gap();
      chk(32'(n), 32'((p + 1) * (a + 1)));
      apb(1'b1, 8'h2c, 32'h0);
      apb(1'b1, 8'h14, 32'h1);
      repeat (4) @(posedge pclk);
      rd(8'h24, 32'h0);
    end
    // slave reset: clears and loads at once, then stop it the same way
    p = int'(rnd() % 4);
    a = int'(rnd() % 7) + 1;
    apb(1'b1, 8'h28, 32'(p));
    apb(1'b1, 8'h2c, 32'(a));
    apb(1'b1, 8'h30, 32'h1);
    gap();
    chk(32'(n), 32'h1);
    gap();
    chk(32'(n), 32'((p + 1) * (a + 1)));
    apb(1'b1, 8'h2c, 32'h0);
    apb(1'b1, 8'h30, 32'h1);
    repeat (4) @(posedge pclk);
    rd(8'h24, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rd(8'h10, 32'h1);
    apb(1'b1, 8'h18, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h2c, 32'h1);
    apb(1'b1, 8'h14, 32'h1);
    repeat (40) @(posedge pclk);
    rd(8'h10, 32'h0);
    test_done();
  end
endmodule
